/* File: inc/rtc_bank_if.sv */
// Carrier between the access controller and the time register bank.
// Assumes a single clock shared by both ends.
`default_nettype none

interface rtc_bank_if;
    logic        wr_one;
    logic [2:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        wr_all;
    logic [55:0] all_data;
    logic [2:0]  rd_addr;
    logic [7:0]  rd_data;
    logic [55:0] bank;

    modport ctl (
        output wr_one, wr_addr, wr_data, wr_all, all_data, rd_addr,
        input  rd_data, bank
    );
    modport mem (
        input  wr_one, wr_addr, wr_data, wr_all, all_data, rd_addr,
        output rd_data, bank
    );
endinterface

`default_nettype wire

/* File: inc/rtc_pkg.sv */
// Types shared by the RTC access block.
// Assumes rtc_regs.svh supplies the numeric constants.
`default_nettype none

package rtc_pkg;
    typedef enum logic [1:0] {
        APB_IDLE   = 2'b00,
        APB_FETCH  = 2'b01,
        APB_ANSWER = 2'b10
    } apb_state_t;
endpackage

`default_nettype wire

/* File: inc/rtc_regs.svh */
// Register indexes, field positions, reset values and timing counts of the RTC access block.
// Assumes a 32-bit APB bus where byte address = 4 * register index.
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Register indexes (byte address is four times the index)
`define RTC_IDX_FLAGS      15'h7ff0
`define RTC_IDX_TIME_FIRST 15'h7ff9
`define RTC_IDX_TIME_LAST  15'h7fff
`define RTC_IDX_INT_STAT   15'h7fe0
`define RTC_IDX_INT_MASK   15'h7fe1

// Flags and control field positions
`define RTC_BIT_READ_CAP   0
`define RTC_BIT_WRITE_HOLD 1
`define RTC_BIT_CAL        2
`define RTC_BIT_TEST       3
`define RTC_FLAGS_RESET    8'h00

// Interrupt event positions
`define RTC_EV_CAPTURE     0
`define RTC_EV_COMMIT      1
`define RTC_EV_SECOND      2
`define RTC_EV_WIDTH       3

// Time bytes, year down to seconds, BCD
`define RTC_TIME_RESET     56'h00_01_01_01_00_00_00
`define RTC_TIME_TOP       56'h99_12_31_07_23_59_59
`define RTC_TIME_LOW       56'h00_01_01_01_00_00_00
`define RTC_TIME_BYTES     7
`define RTC_DAY_SLOT       3

// Timing
`define RTC_CLK_NS         40
`define RTC_SECOND_NS      1000000000

`endif

/* File: rtl/rtc_core.sv */
// Timekeeping core: one-second divider and BCD time/calendar counters.
// Assumes load and run come from logic on the same clock.
`include "rtc_regs.svh"
`default_nettype none

module rtc_core #(
    parameter int unsigned SEC_CYCLES = 25000000
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [55:0] load_val,
    output logic      [55:0] time_q,
    output logic             updating,
    output logic             tick
);
    localparam int unsigned DW = $clog2(SEC_CYCLES + 1);
    localparam logic [55:0] TOP = `RTC_TIME_TOP;
    localparam logic [55:0] LOW = `RTC_TIME_LOW;

    logic [DW-1:0] div_reg;
    logic [55:0]   time_next;
    logic [8:0]    step_r;
    logic          carry;

    // BCD comparison works as binary since digit order is monotonic
    function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                            input logic [7:0] top,
                                            input logic [7:0] low);
        if (v >= top) begin
            return {1'b1, low};
        end else if (v[3:0] >= 4'h9) begin
            return {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            return {1'b0, v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    assign updating = run && (div_reg == DW'(SEC_CYCLES - 1));

    // Day of week wraps on its own; the date chain takes the hours carry
    always_comb begin
        time_next = time_q;
        step_r    = 9'h000;
        carry     = 1'b1;
        for (int i = 0; i < `RTC_TIME_BYTES; i++) begin
            if (carry) begin
                step_r = bcd_step(time_q[i*8 +: 8], TOP[i*8 +: 8], LOW[i*8 +: 8]);
                time_next[i*8 +: 8] = step_r[7:0];
                if (i != `RTC_DAY_SLOT) begin
                    carry = step_r[8];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
            time_q  <= `RTC_TIME_RESET;
            tick    <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (load) begin
                time_q  <= load_val;
                div_reg <= '0;
            end else if (updating) begin
                time_q  <= time_next;
                div_reg <= '0;
                tick    <= 1'b1;
            end else if (run) begin
                div_reg <= div_reg + DW'(1);
            end
        end
    end
endmodule

`default_nettype wire

/* File: rtl/rtc_time_access_control.sv */
// APB-facing flags/control register, time capture and commit handshake of the RTC.
// Assumes an APB master on pclk; instantiates the time bank and timekeeping core.
//
// The APB slave port was left to the implementer.
`include "rtc_regs.svh"
`default_nettype none

module rtc_time_access_control #(
    parameter int unsigned SEC_CYCLES = `RTC_SECOND_NS / `RTC_CLK_NS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [16:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             cal_mode,
    output logic             factory_test_bit
);
    rtc_bank_if bank_if ();

    localparam logic [7:0] FLAGS_RST = `RTC_FLAGS_RESET;

    rtc_pkg::apb_state_t state_reg;
    logic [14:0]              idx;
    logic                     mapped;
    logic                     time_sel;
    logic [31:0]              rd_mux;
    logic                     wr_fire;
    logic                     rd_fire;
    logic                     flags_wr;
    logic                     read_cap_reg;
    logic                     write_hold_reg;
    logic                     cap_pend_reg;
    logic                     cap_go;
    logic                     follow;
    logic                     commit;
    logic [55:0]              core_time;
    logic                     core_updating;
    logic                     core_tick;
    logic [`RTC_EV_WIDTH-1:0] events;
    logic [`RTC_EV_WIDTH-1:0] int_stat_reg;
    logic [`RTC_EV_WIDTH-1:0] int_stat_next;
    logic [`RTC_EV_WIDTH-1:0] int_mask_reg;

    function automatic logic is_time(input logic [14:0] i);
        return (i >= `RTC_IDX_TIME_FIRST) && (i <= `RTC_IDX_TIME_LAST);
    endfunction

    function automatic logic [2:0] time_slot(input logic [14:0] i);
        logic [14:0] d;
        d = i - `RTC_IDX_TIME_FIRST;
        return d[2:0];
    endfunction

    // Address decode
    assign idx      = paddr[16:2];
    assign time_sel = (paddr[1:0] == 2'b00) && is_time(idx);
    assign mapped   = (paddr[1:0] == 2'b00) &&
                      (idx == `RTC_IDX_FLAGS || is_time(idx) ||
                       idx == `RTC_IDX_INT_STAT || idx == `RTC_IDX_INT_MASK);

    // A transfer completes in the cycle that pready stands high
    assign wr_fire  = (state_reg == rtc_pkg::APB_ANSWER) && pwrite && mapped;
    assign rd_fire  = (state_reg == rtc_pkg::APB_ANSWER) && !pwrite && mapped;
    assign flags_wr = wr_fire && (idx == `RTC_IDX_FLAGS);

    // Falling write-hold commits the bank into the counters
    assign commit = flags_wr && write_hold_reg && !pwdata[`RTC_BIT_WRITE_HOLD];

    // Snapshot waits out a counter step landing in this cycle
    assign cap_go = cap_pend_reg && !core_updating;
    // Bank tracks the counters only while neither captured nor held
    assign follow = core_tick && !read_cap_reg && !write_hold_reg;

    assign bank_if.wr_all   = cap_go || follow;
    assign bank_if.all_data = core_time;
    // Host time writes only land while held, so only a capture request (cap_go) can overwrite them
    assign bank_if.wr_one   = wr_fire && time_sel && write_hold_reg;
    assign bank_if.wr_addr  = time_slot(idx);
    assign bank_if.wr_data  = pwdata[7:0];
    assign bank_if.rd_addr  = time_slot(idx);

    rtc_time_bank u_bank (
        .clk   (pclk),
        .rst_n (presetn),
        .port  (bank_if.mem)
    );

    rtc_core #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_core (
        .clk      (pclk),
        .rst_n    (presetn),
        .run      (!write_hold_reg),
        .load     (commit),
        .load_val (bank_if.bank),
        .time_q   (core_time),
        .updating (core_updating),
        .tick     (core_tick)
    );

    // Read data; unused flag bits read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (idx == `RTC_IDX_FLAGS) begin
            rd_mux[`RTC_BIT_READ_CAP]   = read_cap_reg;
            rd_mux[`RTC_BIT_WRITE_HOLD] = write_hold_reg;
            rd_mux[`RTC_BIT_CAL]        = cal_mode;
            rd_mux[`RTC_BIT_TEST]       = factory_test_bit;
        end else if (time_sel) begin
            rd_mux[7:0] = bank_if.rd_data;
        end else if (idx == `RTC_IDX_INT_STAT) begin
            rd_mux[`RTC_EV_WIDTH-1:0] = int_stat_reg;
        end else if (idx == `RTC_IDX_INT_MASK) begin
            rd_mux[`RTC_EV_WIDTH-1:0] = int_mask_reg;
        end
    end

    // APB handshake: one fetch cycle lets the bank's registered read settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= rtc_pkg::APB_IDLE;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h0000_0000;
        end else begin
            case (state_reg)
                rtc_pkg::APB_IDLE: begin
                    if (psel && penable) begin
                        state_reg <= rtc_pkg::APB_FETCH;
                    end
                end
                rtc_pkg::APB_FETCH: begin
                    state_reg <= rtc_pkg::APB_ANSWER;
                    pready    <= 1'b1;
                    pslverr   <= !mapped;
                    prdata    <= (pwrite || !mapped) ? 32'h0000_0000 : rd_mux;
                end
                rtc_pkg::APB_ANSWER: begin
                    state_reg <= rtc_pkg::APB_IDLE;
                    pready    <= 1'b0;
                    pslverr   <= 1'b0;
                end
                default: begin
                    state_reg <= rtc_pkg::APB_IDLE;
                    pready    <= 1'b0;
                    pslverr   <= 1'b0;
                end
            endcase
        end
    end

    // Flags and control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_cap_reg     <= FLAGS_RST[`RTC_BIT_READ_CAP];
            write_hold_reg   <= FLAGS_RST[`RTC_BIT_WRITE_HOLD];
            cal_mode         <= FLAGS_RST[`RTC_BIT_CAL];
            factory_test_bit <= FLAGS_RST[`RTC_BIT_TEST];
        end else if (flags_wr) begin
            read_cap_reg     <= pwdata[`RTC_BIT_READ_CAP];
            write_hold_reg   <= pwdata[`RTC_BIT_WRITE_HOLD];
            cal_mode         <= pwdata[`RTC_BIT_CAL];
            // Stored as written; software is expected to leave it at 0
            factory_test_bit <= pwdata[`RTC_BIT_TEST];
        end
    end

    // Capture request armed only by a rising read-capture bit; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_pend_reg <= 1'b0;
        end else if (flags_wr && pwdata[`RTC_BIT_READ_CAP] && !read_cap_reg) begin
            cap_pend_reg <= 1'b1;
        end else if (cap_go) begin
            cap_pend_reg <= 1'b0;
        end
    end

    // Sticky events; a status read clears only the bits it returned
    always_comb begin
        events = '0;
        events[`RTC_EV_CAPTURE] = cap_go;
        events[`RTC_EV_COMMIT]  = commit;
        events[`RTC_EV_SECOND]  = core_tick;
        int_stat_next = int_stat_reg;
        if (rd_fire && idx == `RTC_IDX_INT_STAT) begin
            int_stat_next = int_stat_reg & ~prdata[`RTC_EV_WIDTH-1:0];
        end
        int_stat_next = int_stat_next | events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= '0;
        end else begin
            int_stat_reg <= int_stat_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_reg <= '0;
        end else if (wr_fire && idx == `RTC_IDX_INT_MASK) begin
            int_mask_reg <= pwdata[`RTC_EV_WIDTH-1:0];
        end
    end

    // Calibration mode silences the interrupt; events still latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_reg & int_mask_reg) && !cal_mode;
        end
    end
endmodule

`default_nettype wire

/* File: rtl/rtc_time_bank.sv */
// Seven-byte user time register bank with registered read data.
// Assumes writes come from the access controller on the same clock.
`include "rtc_regs.svh"
`default_nettype none

module rtc_time_bank (
    input  wire logic   clk,
    input  wire logic   rst_n,
    rtc_bank_if.mem     port
);
    logic [7:0] mem_q [`RTC_TIME_BYTES];

    // Whole-bank load beats a single byte write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `RTC_TIME_BYTES; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (port.wr_all) begin
            for (int i = 0; i < `RTC_TIME_BYTES; i++) begin
                mem_q[i] <= port.all_data[i*8 +: 8];
            end
        end else if (port.wr_one && port.wr_addr < 3'(`RTC_TIME_BYTES)) begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port.rd_data <= 8'h00;
        end else if (port.rd_addr < 3'(`RTC_TIME_BYTES)) begin
            port.rd_data <= mem_q[port.rd_addr];
        end else begin
            port.rd_data <= 8'h00;
        end
    end

    always_comb begin
        for (int i = 0; i < `RTC_TIME_BYTES; i++) begin
            port.bank[i*8 +: 8] = mem_q[i];
        end
    end
endmodule

`default_nettype wire

/* File: sim/host_apb_model.sv */
// Host processor model: APB master issuing one transfer per call.
// Assumes the slave answers with pready on pclk; only the bench timeout ends a wait.
`default_nettype none

module host_apb_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [16:0] paddr,
    output logic      [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 17'h0;
        pwdata = 32'h0;
    end

    task automatic xfer(input logic [16:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= (a == 17'h1ffc0) ? (d & 32'hffff_fff7) : d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* File: sim/rtc_sva.sv */
// Checker for the RTC access block: bus timing, error answers, flag outputs.
// Assumes it is bound to rtc_time_access_control and sees only its ports.
`include "rtc_regs.svh"
`default_nettype none

module rtc_sva #(
    parameter int unsigned SEC_CYCLES = 20
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [16:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        cal_mode,
    input wire logic        factory_test_bit
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [14:0] idx;
    logic        mapped;
    logic        flag_wr;
    assign idx     = paddr[16:2];
    assign mapped  = (paddr[1:0] == 2'h0) && (idx == `RTC_IDX_FLAGS || idx == `RTC_IDX_INT_STAT
                     || idx == `RTC_IDX_INT_MASK
                     || (idx >= `RTC_IDX_TIME_FIRST && idx <= `RTC_IDX_TIME_LAST));
    assign flag_wr = psel && penable && pready && pwrite && mapped && idx == `RTC_IDX_FLAGS;

    a_ready_delay: assert property ($rose(psel && penable) |-> !pready ##1 !pready ##1 pready)
        else $error("pready not two cycles after access start");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held more than one cycle");
    a_unmapped_err: assert property ($rose(psel && penable) && !mapped |-> ##2 pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property ($rose(psel && penable) && mapped |-> ##2 !pslverr)
        else $error("mapped access refused");
    a_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("write answer carries data");
    a_cal_follow: assert property (flag_wr |=> cal_mode == $past(pwdata[`RTC_BIT_CAL]))
        else $error("calibration output does not follow write");
    a_test_follow: assert property (flag_wr |=> factory_test_bit == $past(pwdata[3]))
        else $error("test bit output does not follow write");
    a_cal_quiet: assert property (cal_mode && $past(cal_mode) |-> !irq)
        else $error("interrupt raised in calibration mode");
    a_flags_upper: assert property (pready && !pwrite && idx == `RTC_IDX_FLAGS
                                    |-> prdata[31:4] == 28'h0)
        else $error("flag read upper bits not zero");

    c_refused: cover property (pready && pslverr);
    c_flag_write: cover property (flag_wr && pwdata[0]);
    c_irq_rise: cover property ($rose(irq));
endmodule

bind rtc_time_access_control rtc_sva #(.SEC_CYCLES(SEC_CYCLES)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .cal_mode(cal_mode), .factory_test_bit(factory_test_bit)
);

`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench of the RTC access block with a queue of expected answers.
// Assumes a shortened second of 20 clocks and the host model as APB master.
`include "rtc_regs.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [16:0] FL = {`RTC_IDX_FLAGS, 2'b00};
    localparam logic [16:0] TS = {`RTC_IDX_TIME_FIRST, 2'b00};
    localparam logic [16:0] ST = {`RTC_IDX_INT_STAT, 2'b00};
    localparam logic [16:0] MK = {`RTC_IDX_INT_MASK, 2'b00};
    localparam logic [32:0] ALL = {33{1'b1}};

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, irq, cal_mode, factory_test_bit;
    logic [16:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [65:0] q[$];
    logic [65:0] ent;
    logic [31:0] seed = 32'd40898;
    logic [7:0]  sec, mnt;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cyc = 0;

    rtc_time_access_control #(.SEC_CYCLES(20)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .cal_mode(cal_mode), .factory_test_bit(factory_test_bit)
    );
    host_apb_model host (
        .pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
    );

    initial begin
        forever #20 pclk = ~pclk;
    end

    function automatic logic [7:0] bcd_rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {4'((seed % 60) / 10), 4'((seed % 60) % 10)};
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        // An answer that never came leaves its note behind
        if (q.size() != 0)
            error_cnt++;
        $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Note first, then drive, so the watcher always finds its entry
    task automatic acc(input logic [16:0] a, input logic w, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        q.push_back({m, e});
        host.xfer(a, w, d, rd);
    endtask

    always @(posedge pclk) begin
        if (presetn && psel && penable && pready === 1'b1 && q.size() > 0) begin
            ent = q.pop_front();
            check({pslverr, prdata} & ent[65:33], ent[32:0] & ent[65:33]);
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        acc(FL, 1'b0, 32'h0, 33'h0, ALL);
        acc(17'h1ffc4, 1'b0, 32'h0, {1'b1, 32'h0}, ALL);
        acc(TS + 17'h2, 1'b0, 32'h0, {1'b1, 32'h0}, ALL);
        acc(FL, 1'b1, 32'h2, 33'h0, ALL);
        sec = bcd_rnd();
        mnt = bcd_rnd();
        acc(TS, 1'b1, {24'h0, sec}, 33'h0, ALL);
        acc(TS + 17'h4, 1'b1, {24'h0, mnt}, 33'h0, ALL);
        repeat (60) @(posedge pclk);
        acc(TS, 1'b0, 32'h0, {9'h0, 16'h0, sec}, ALL);
        acc(TS + 17'h4, 1'b0, 32'h0, {9'h0, 16'h0, mnt}, ALL);
        acc(FL, 1'b1, 32'h0, 33'h0, ALL);
        acc(FL, 1'b1, 32'h1, 33'h0, ALL);
        acc(TS, 1'b0, 32'h0, {9'h0, 16'h0, sec}, ALL);
        acc(TS + 17'h4, 1'b0, 32'h0, {9'h0, 16'h0, mnt}, ALL);
        repeat (70) @(posedge pclk);
        acc(FL, 1'b1, 32'h1, 33'h0, ALL);
        acc(TS, 1'b0, 32'h0, {9'h0, 16'h0, sec}, ALL);
        // Fresh image needs the bit lowered first
        acc(FL, 1'b1, 32'h0, 33'h0, ALL);
        acc(FL, 1'b1, 32'h1, 33'h0, ALL);
        acc(TS, 1'b0, 32'h0, 33'h0, {1'b1, 32'h0});
        check({32'h0, (rd[7:0] !== sec) && !$isunknown(rd[7:0])}, 33'h1);
        acc(MK, 1'b1, 32'h7, 33'h0, ALL);
        repeat (3) @(posedge pclk);
        check({32'h0, irq}, 33'h1);
        acc(MK, 1'b1, 32'h1, 33'h0, ALL);
        acc(ST, 1'b0, 32'h0, 33'h3, {1'b1, 32'h3});
        repeat (3) @(posedge pclk);
        check({32'h0, irq}, 33'h0);
        acc(FL, 1'b1, 32'h0, 33'h0, ALL);
        acc(FL, 1'b1, 32'h1, 33'h0, ALL);
        repeat (3) @(posedge pclk);
        check({32'h0, irq}, 33'h1);
        acc(FL, 1'b1, 32'h5, 33'h0, ALL);
        repeat (3) @(posedge pclk);
        check({31'h0, cal_mode, irq}, 33'h2);
        acc(FL, 1'b1, 32'h1, 33'h0, ALL);
        repeat (3) @(posedge pclk);
        check({31'h0, cal_mode, irq}, 33'h1);
        acc(FL, 1'b0, 32'h0, 33'h1, ALL);
        check({32'h0, factory_test_bit}, 33'h0);
        repeat (2) @(posedge pclk);
        print_verdict();
    end
endmodule

`default_nettype wire
